/* dv/haptic_event_diagnostics_tb.sv */
// Testbench for hev_core: flags, masks, clearing, frequency checks, hold.
// Assumes hev_host_model as bus master and pull-up.
`timescale 1ns/100ps
module haptic_event_diagnostics_tb
  import hev_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [13:0] ev = 14'h0;
  logic        fv = 1'b0;
  logic [15:0] fhz = 16'h0;
  logic        preq = 1'b0;
  logic        pend = 1'b0;
  logic [11:0] haddr;
  logic [1:0]  htr;
  logic [1:0]  dst;
  logic [31:0] hwd;
  logic [31:0] hrd;
  logic [31:0] r;
  logic        hwr;
  logic        rdy;
  logic        oe;
  logic        pin;
  int          err_count = 0;
  int          checks = 0;
  int          m[4];
  int          ma;
  int          mb;
  // Flag register and bit of each event input, in the order of ev.
  int          er[14] = '{0, 0, 0, 0, 0, 3, 3, 3, 1, 1, 1, 2, 2, 2};
  int          eb[14] = '{0, 1, 1, 3, 4, 0, 1, 2, 0, 1, 3, 0, 1, 2};
  int          fq[5] = '{49, 50, 300, 301, 0};
  // Clock of 40 ns.
  always #20 clk = ~clk;
  hev_core uut (.clk_i(clk), .rst_i(rst), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htr), .hwrite_i(hwr),
    .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy), .hresp_o(),
    .overcurrent_i(ev[0]), .impedance_err_i(ev[1]), .bemf_err_i(ev[2]), .overtemp_crit_i(ev[3]),
    .undervoltage_i(ev[4]), .bad_seq_id_i(ev[5]), .mem_corrupt_i(ev[6]), .pwm_timeout_i(ev[7]),
    .seq_done_i(ev[8]), .seq_repeat_start_i(ev[9]), .sense_adc_sat_i(ev[10]), .batt_below_target_i(ev[11]),
    .batt_below_overdrive_i(ev[12]), .mem_type_mismatch_i(ev[13]), .freq_valid_i(fv), .freq_hz_i(fhz),
    .play_req_i(preq), .play_end_i(pend), .drive_en_o(), .drv_state_o(dst), .irq_out_n_o(),
    .irq_out_n_oe_o(oe));
  hev_host_model host (.clk_i(clk), .haddr_o(haddr), .htrans_o(htr), .hwrite_o(hwr), .hwdata_o(hwd),
    .hready_i(rdy), .hrdata_i(hrd), .irq_oe_i(oe), .irq_pin_o(pin));
  // Counts a comparison and reports a mismatch.
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // Pulses one event for a cycle and updates the model.
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 14'h1 << i;
    @(posedge clk);
    ev <= 14'h0;
    repeat (3) @(posedge clk);
    m[er[i]] |= 1 << eb[i];
    if (er[i] == 3) m[0] |= 4;
    if (er[i] == 2) m[1] |= 4;
  endtask : pulse
  // Reads the four flag registers and the pin.
  task automatic chk_all();
    int p;
    for (int i = 0; i < 4; i++) begin
      host.xfer(12'(4 * i), 1'b0, 32'h0, r);
      cmp(r, m[i]);
    end
    p = (m[0] & ~ma & 'h1f) | (m[3] & ~(ma >> 5) & 7) | (m[1] & ~mb & 'hf) | (m[2] & ~(mb >> 4) & 7);
    cmp({31'h0, pin}, {31'h0, p == 0});
  endtask : chk_all
  // Clears warnings before the summary flag, so it cannot re-set.
  task automatic clr_all();
    foreach (m[i])
      host.xfer(12'(4 * ((i + 2) % 4)), 1'b1, 32'hffffffff, r);
    m = '{0, 0, 0, 0};
    repeat (3) @(posedge clk);
  endtask : clr_all
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // Watchdog.
  initial begin
    #800000;
    err_count++;
    complete_run();
  end
  // Main sequence.
  initial begin
    void'($urandom(50));
    m = '{0, 0, 0, 0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      host.xfer(12'(4 * i), 1'b0, 32'h0, r);
      cmp(r, i == 7 ? 32'h012c0032 : 32'h0);
    end
    // Every event, first with all masks set, then with none.
    for (int k = 1; k >= 0; k--) begin
      ma = k * 'hff;
      mb = k * 'h7f;
      host.xfer(12'h010, 1'b1, 32'(ma), r);
      host.xfer(12'h014, 1'b1, 32'(mb), r);
      for (int i = 0; i < 14; i++) begin
        pulse(i);
        chk_all();
        foreach (m[j])
          host.xfer(12'(4 * j), 1'b1, 32'h0, r);
        chk_all();
        clr_all();
        chk_all();
      end
    end
    // Frequency at the band edges and at random in band, per check setting.
    for (int c = 0; c < 3; c++) begin
      host.xfer(12'h018, 1'b1, 32'(c), r);
      foreach (fq[j]) begin
        @(posedge clk);
        fv <= 1'b1;
        fhz <= 16'(j == 4 ? 50 + $urandom % 251 : fq[j]);
        @(posedge clk);
        fv <= 1'b0;
        repeat (3) @(posedge clk);
        if (c == 0 && (fhz < 50 || fhz > 300)) m[0] |= 2;
        chk_all();
        clr_all();
      end
    end
    // A warning keeps playback; a fault holds until cleared.
    host.xfer(12'h018, 1'b1, 32'h4, r);
    preq <= 1'b1;
    pulse(11);
    host.xfer(12'h020, 1'b0, 32'h0, r);
    cmp(r, 32'h5);
    cmp({30'h0, dst}, 32'h1);
    pulse(0);
    host.xfer(12'h020, 1'b0, 32'h0, r);
    cmp(r, 32'h6);
    cmp({30'h0, dst}, 32'h2);
    clr_all();
    host.xfer(12'h020, 1'b0, 32'h0, r);
    cmp(r, 32'h1);
    cmp({30'h0, dst}, 32'h1);
    preq <= 1'b0;
    pulse(2);
    m[0] = 0;
    chk_all();
    @(posedge clk);
    pend <= 1'b1;
    @(posedge clk);
    pend <= 1'b0;
    host.xfer(12'h020, 1'b0, 32'h0, r);
    cmp(r, 32'h0);
    cmp({30'h0, dst}, 32'h0);
    host.xfer(12'h018, 1'b1, 32'h8, r);
    pulse(4);
    m[0] = 0;
    repeat (5) @(posedge clk);
    chk_all();
    complete_run();
  end
endmodule : haptic_event_diagnostics_tb

/* dv/hev_checker.sv */
// Checker: state, pin and bus relations of hev_core.
// Assumes a bind onto hev_core and sight of its ports only.
`timescale 1ns/100ps
module hev_checker
  import hev_pkg::*;
(
  // Clock and reset.
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Sources.
  input wire logic       overcurrent_i,
  input wire logic       undervoltage_i,
  input wire logic       impedance_err_i,
  input wire logic       bemf_err_i,
  input wire logic       overtemp_crit_i,
  input wire logic       bad_seq_id_i,
  input wire logic       mem_corrupt_i,
  input wire logic       pwm_timeout_i,
  input wire logic       freq_valid_i,
  input wire logic       batt_below_target_i,
  input wire logic       play_req_i,
  input wire logic       play_end_i,
  // Outputs.
  input wire logic       drive_en_o,
  input wire logic [1:0] drv_state_o,
  input wire logic       irq_out_n_o,
  input wire logic       irq_out_n_oe_o,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Fault sources that no setting can disable.
  wire flt = overcurrent_i | undervoltage_i | impedance_err_i | overtemp_crit_i | bad_seq_id_i | mem_corrupt_i
    | pwm_timeout_i;
  // Every source that may fault, depending on configuration.
  wire flt_any = flt | bemf_err_i | freq_valid_i;
  chk_fault_hold: assert property (flt |-> ##[1:2] drv_state_o == HEV_HOLD)
    else $error("no hold after fault");
  chk_drive_state: assert property (drive_en_o == (drv_state_o == HEV_DRIVE))
    else $error("drive enable off state");
  chk_hold_exit: assert property (drv_state_o == HEV_HOLD |=> drv_state_o != HEV_DRIVE)
    else $error("hold went to drive");
  chk_warn_keeps: assert property (batt_below_target_i && drv_state_o == HEV_DRIVE && !flt_any && !$past(flt_any)
    && !play_end_i |=> drv_state_o == HEV_DRIVE)
    else $error("warning stopped drive");
  chk_idle_start: assert property (drv_state_o == HEV_IDLE && play_req_i && !flt_any && !$past(flt_any)
    |=> drv_state_o == HEV_DRIVE)
    else $error("idle refused play");
  chk_pin_low: assert property (irq_out_n_o == 1'b0)
    else $error("pin level not low");
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus not okay");
  chk_state_legal: assert property (drv_state_o != 2'b11)
    else $error("bad state");
  // Main scenarios.
  cover property (drv_state_o == HEV_HOLD ##1 drv_state_o == HEV_IDLE);
  cover property ($rose(irq_out_n_oe_o));
  cover property (drv_state_o == HEV_DRIVE && batt_below_target_i);
endmodule : hev_checker
bind hev_core hev_checker chk (.clk_i, .rst_i, .overcurrent_i, .undervoltage_i, .impedance_err_i, .bemf_err_i,
  .overtemp_crit_i, .bad_seq_id_i, .mem_corrupt_i, .pwm_timeout_i, .freq_valid_i, .batt_below_target_i,
  .play_req_i, .play_end_i, .drive_en_o, .drv_state_o, .irq_out_n_o, .irq_out_n_oe_o, .hreadyout_o, .hresp_o);

/* dv/hev_host_model.sv */
// Host model: AHB-Lite master task and the pulled-up interrupt wire.
// Assumes one zero-wait slave whose hreadyout is its hready.
`timescale 1ns/100ps
module hev_host_model (
  // Clock.
  input  wire logic        clk_i,
  // Bus master side.
  output logic [11:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [31:0]      hwdata_o,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  // Interrupt pin.
  input  wire logic        irq_oe_i,
  output logic             irq_pin_o
);
  // The pull-up holds the pin high unless the device pulls it low.
  assign irq_pin_o = irq_oe_i ? 1'b0 : 1'b1;
  // Idle bus at time zero.
  initial begin
    haddr_o = 12'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
  end
  // One single transfer; read data is taken at the data-phase edge.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    haddr_o <= a;
    hwrite_o <= w;
    htrans_o <= 2'h2;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    r = hrdata_i;
    hwdata_o <= ~d; // Released data never keeps its last value.
  endtask : xfer
endmodule : hev_host_model

/* logic/hev_consts.svh */
// Constants for the haptic event diagnostics block: offsets, fields, resets.
// Assumes inclusion by the package and the design file only.
`ifndef HEV_CONSTS_SVH
`define HEV_CONSTS_SVH

// Register byte offsets.
`define HEV_OFF_FAULT      12'h000
`define HEV_OFF_NOTIFY     12'h004
`define HEV_OFF_WARN       12'h008
`define HEV_OFF_SEQDIAG    12'h00c
`define HEV_OFF_MASK_A     12'h010
`define HEV_OFF_MASK_B     12'h014
`define HEV_OFF_CFG        12'h018
`define HEV_OFF_FREQ       12'h01c
`define HEV_OFF_STATUS     12'h020

// Fault byte fields.
`define HEV_F_OC           0
`define HEV_F_ACT          1
`define HEV_F_SEQ          2
`define HEV_F_OTC          3
`define HEV_F_UV           4
// Notification fields.
`define HEV_N_DONE         0
`define HEV_N_REPEAT       1
`define HEV_N_WARN         2
`define HEV_N_ADC          3
// Warning fields.
`define HEV_W_DRIVE        0
`define HEV_W_ACCEL        1
`define HEV_W_MEMTYPE      2
// Sequence diagnostic fields.
`define HEV_S_ID           0
`define HEV_S_MEM          1
`define HEV_S_PWM          2
// Configuration fields.
`define HEV_C_BYPASS       0
`define HEV_C_FTRK_DIS     1
`define HEV_C_BEMF_DIS     2
`define HEV_C_EMBED        3

// Reset values.
`define HEV_RST_MASK       8'h00
`define HEV_RST_CFG        4'h0
`define HEV_RST_FREQ_LO    16'd50
`define HEV_RST_FREQ_HI    16'd300

`endif

/* logic/hev_core.sv */
// Event, warning and fault collection with masking and an open-drain interrupt.
// Assumes an AHB-Lite master on clk_i and event inputs from the driver on the same clock,
// except the frequency value, which is a plain number of hertz on the same clock.
// Only whole-word transfers are supported; the transfer size is not checked.
//
// How it works
// - Fault forces hold, refuses playback until cleared.
// - Warnings, notifications never change state.
// - Any unmasked event pulls interrupt low.
// - Five faults share one fault event byte.
// - Three warnings held in warning register.
// - Sequence fault set; cause in diagnostic register.
// - Missing sequence identifier flags identifier fault.
// - Memory corruption flags memory fault.
// - PWM timeout flags fault; host clears sequence flag.
// - Sequence completion sets done flag.
// - Continue-triggered restart sets repeat flag.
// - Summary warning flag while warning active.
// - Sense converter saturation sets flag.
// - Actuator anomaly raises actuator fault.
// - Battery limits raise drive, accel warnings.
// - Memory format mismatch raises type warning.
// - Flags clear by writing one.
// - Two mask registers gate every event.
// - Tracking and back-EMF checks separately disableable.
// - Frequency outside 50-300 Hz faults actuator.
// - Bypass bit suppresses frequency range checks.
// - Embedded mode auto-clears faults in hold.
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "hev_consts.svh"
module hev_core
  import hev_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [11:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Driver fault sources, one-cycle pulses.
  input  wire logic        overcurrent_i,
  input  wire logic        impedance_err_i,
  input  wire logic        bemf_err_i,
  input  wire logic        overtemp_crit_i,
  input  wire logic        undervoltage_i,
  input  wire logic        bad_seq_id_i,
  input  wire logic        mem_corrupt_i,
  input  wire logic        pwm_timeout_i,
  // Notification and warning sources.
  input  wire logic        seq_done_i,
  input  wire logic        seq_repeat_start_i,
  input  wire logic        sense_adc_sat_i,
  input  wire logic        batt_below_target_i,
  input  wire logic        batt_below_overdrive_i,
  input  wire logic        mem_type_mismatch_i,
  // Frequency tracking.
  input  wire logic        freq_valid_i,
  input  wire logic [15:0] freq_hz_i,
  // Playback control from the sequencer.
  input  wire logic        play_req_i,
  input  wire logic        play_end_i,
  output logic             drive_en_o,
  output logic [1:0]       drv_state_o,
  // Interrupt pin, open drain, active low.
  output logic             irq_out_n_o,
  output logic             irq_out_n_oe_o
);

  // Bus address phase capture.
  logic        wr_q;
  logic [11:0] addr_q;

  // Flag and configuration storage.
  logic [4:0]  fault_event_byte_q;
  logic [3:0]  notify_q;
  logic [2:0]  warning_diag_reg_q;
  logic [2:0]  seq_input_diag_reg_q;
  logic [7:0]  event_mask_a_q;
  logic [7:0]  event_mask_b_q;
  logic [3:0]  cfg_q;
  logic [15:0] freq_lo_q;
  logic [15:0] freq_hi_q;
  hev_state_t  state_q;
  logic        irq_q;

  // Derived terms.
  logic        wr_fault;
  logic        wr_notify;
  logic        wr_warn;
  logic        wr_seq;
  logic [4:0]  fault_set;
  logic [3:0]  notify_set;
  logic [2:0]  warn_set;
  logic [2:0]  seq_set;
  logic        freq_bad;
  logic        auto_clr;
  logic        pend_fault;
  logic        pend_notify;
  logic        pend_warn;
  logic        pend_seq;
  logic        any_event;
  logic [31:0] rdata_d;

  // Clears flags with write-one, keeping a same-cycle set.
  function automatic logic [4:0] w1c(input logic [4:0] cur, input logic [4:0] set,
                                     input logic we, input logic [4:0] data);
    w1c = (cur & ~(we ? data : 5'h00)) | set;
  endfunction : w1c

  // A transfer is requested when the slave is selected with a non-sequential or sequential type.
  function automatic logic xfer_req(input logic sel, input logic [1:0] trans);
    xfer_req = sel & trans[1];
  endfunction : xfer_req

  // Address phase is taken when selected and the bus is ready.
  // Holding the capture while hready is low keeps a stalled address phase intact.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q   <= 1'b0;
      addr_q <= 12'h000;
    end else if (hready_i) begin
      wr_q   <= xfer_req(hsel_i, htrans_i) & hwrite_i;
      addr_q <= haddr_i;
    end
  end

  // The slave never stalls and always answers OKAY.
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // Write strobes per register, valid in the data phase that follows the address.
  assign wr_fault  = wr_q && (addr_q == `HEV_OFF_FAULT);
  assign wr_notify = wr_q && (addr_q == `HEV_OFF_NOTIFY);
  assign wr_warn   = wr_q && (addr_q == `HEV_OFF_WARN);
  assign wr_seq    = wr_q && (addr_q == `HEV_OFF_SEQDIAG);

  // Frequency range check, with bypass and tracking disable.
  // The limits are inclusive, so the limit values themselves are in range.
  assign freq_bad = freq_valid_i && !cfg_q[`HEV_C_BYPASS] && !cfg_q[`HEV_C_FTRK_DIS]
                    && ((freq_hz_i < freq_lo_q) || (freq_hz_i > freq_hi_q));

  // Input data fault causes.
  always_comb begin
    seq_set = 3'b000;
    seq_set[`HEV_S_ID]  = bad_seq_id_i;
    seq_set[`HEV_S_MEM] = mem_corrupt_i;
    seq_set[`HEV_S_PWM] = pwm_timeout_i;
  end

  // Fault event sources gathered into one byte.
  always_comb begin
    fault_set = 5'h00;
    fault_set[`HEV_F_OC]  = overcurrent_i;
    fault_set[`HEV_F_ACT] = impedance_err_i | (bemf_err_i & ~cfg_q[`HEV_C_BEMF_DIS]) | freq_bad;
    fault_set[`HEV_F_SEQ] = |seq_set;
    fault_set[`HEV_F_OTC] = overtemp_crit_i;
    fault_set[`HEV_F_UV]  = undervoltage_i;
  end

  // Warning sources.
  always_comb begin
    warn_set = 3'b000;
    warn_set[`HEV_W_DRIVE]   = batt_below_target_i;
    warn_set[`HEV_W_ACCEL]   = batt_below_overdrive_i;
    warn_set[`HEV_W_MEMTYPE] = mem_type_mismatch_i;
  end

  // Notification sources; the summary follows any held warning.
  // The summary re-sets while a warning is stored, so software clears warnings first.
  always_comb begin
    notify_set = 4'h0;
    notify_set[`HEV_N_DONE]   = seq_done_i;
    notify_set[`HEV_N_REPEAT] = seq_repeat_start_i;
    notify_set[`HEV_N_WARN]   = |warning_diag_reg_q | |warn_set;
    notify_set[`HEV_N_ADC]    = sense_adc_sat_i;
  end

  // Embedded mode clears faults while the driver sits in the hold state.
  // The clear lags the fault by one cycle, so the interrupt only pulses briefly.
  assign auto_clr = cfg_q[`HEV_C_EMBED] && (state_q == HEV_HOLD);

  // Fault byte, cleared by write-one or by embedded auto clear.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_event_byte_q <= 5'h00;
    end else if (auto_clr) begin
      fault_event_byte_q <= fault_set;
    end else begin
      fault_event_byte_q <= w1c(fault_event_byte_q, fault_set, wr_fault, hwdata_i[4:0]);
    end
  end

  // Sequence cause register; clears with the sequence fault flag too.
  // A cause arriving in the clearing cycle is kept, so the set wins.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_input_diag_reg_q <= 3'b000;
    end else if (auto_clr || (wr_fault && hwdata_i[`HEV_F_SEQ])) begin
      seq_input_diag_reg_q <= seq_set;
    end else begin
      seq_input_diag_reg_q <= 3'(w1c({2'b00, seq_input_diag_reg_q}, {2'b00, seq_set},
                                     wr_seq, hwdata_i[4:0]));
    end
  end

  // Warning register, write-one to clear.
  // Warnings are never cleared automatically; they only inform the host.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      warning_diag_reg_q <= 3'b000;
    end else begin
      warning_diag_reg_q <= 3'(w1c({2'b00, warning_diag_reg_q}, {2'b00, warn_set},
                                   wr_warn, hwdata_i[4:0]));
    end
  end

  // Notification register, write-one to clear.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      notify_q <= 4'h0;
    end else begin
      notify_q <= 4'(w1c({1'b0, notify_q}, {1'b0, notify_set}, wr_notify, hwdata_i[4:0]));
    end
  end

  // Masks, configuration and frequency limits, plainly written.
  // Writes to unmapped offsets fall through and are ignored.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_mask_a_q <= `HEV_RST_MASK;
      event_mask_b_q <= `HEV_RST_MASK;
      cfg_q          <= `HEV_RST_CFG;
      freq_lo_q      <= `HEV_RST_FREQ_LO;
      freq_hi_q      <= `HEV_RST_FREQ_HI;
    end else if (wr_q) begin
      case (addr_q)
        `HEV_OFF_MASK_A: begin
          event_mask_a_q <= hwdata_i[7:0];
        end
        `HEV_OFF_MASK_B: begin
          event_mask_b_q <= hwdata_i[7:0];
        end
        `HEV_OFF_CFG: begin
          cfg_q <= hwdata_i[3:0];
        end
        `HEV_OFF_FREQ: begin
          freq_lo_q <= hwdata_i[15:0];
          freq_hi_q <= hwdata_i[31:16];
        end
        default: begin
        end
      endcase
    end
  end

  // Driver state: faults force the hold state, warnings never touch it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= HEV_IDLE;
    end else begin
      case (state_q)
        HEV_IDLE: begin
          // A stored fault is honoured before any new playback request.
          if (|fault_event_byte_q || |fault_set) begin
            state_q <= HEV_HOLD;
          end else if (play_req_i) begin
            state_q <= HEV_DRIVE;
          end
        end
        HEV_DRIVE: begin
          if (|fault_set) begin
            state_q <= HEV_HOLD;
          end else if (play_end_i) begin
            state_q <= HEV_IDLE;
          end
        end
        HEV_HOLD: begin
          // Leaves only once every fault is gone, so playback stays refused.
          if (fault_event_byte_q == 5'h00 && fault_set == 5'h00) begin
            state_q <= HEV_IDLE;
          end
        end
        default: begin
          state_q <= HEV_IDLE;
        end
      endcase
    end
  end

  // Playback is enabled only in the drive state; the state itself is shown as well.
  assign drive_en_o  = (state_q == HEV_DRIVE);
  assign drv_state_o = state_q;

  // Pending terms per register; a masked flag stays stored but is not pending.
  assign pend_fault  = |(fault_event_byte_q & ~event_mask_a_q[4:0]);
  assign pend_seq    = |(seq_input_diag_reg_q & ~event_mask_a_q[7:5]);
  assign pend_notify = |(notify_q & ~event_mask_b_q[3:0]);
  assign pend_warn   = |(warning_diag_reg_q & ~event_mask_b_q[6:4]);

  // Interrupt request: any pending term at all.
  assign any_event = pend_fault | pend_seq | pend_notify | pend_warn;

  // Registered request, so the pin never glitches while flags settle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= any_event;
    end
  end

  // Pin only ever drives low; released means enable off.
  // The pull-up outside the device supplies the high level.
  assign irq_out_n_o    = 1'b0;
  assign irq_out_n_oe_o = irq_q;

  // Read data mux, decoded from the address phase.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr_i)
      `HEV_OFF_FAULT: begin
        rdata_d = {27'h0, fault_event_byte_q};
      end
      `HEV_OFF_NOTIFY: begin
        rdata_d = {28'h0, notify_q};
      end
      `HEV_OFF_WARN: begin
        rdata_d = {29'h0, warning_diag_reg_q};
      end
      `HEV_OFF_SEQDIAG: begin
        rdata_d = {29'h0, seq_input_diag_reg_q};
      end
      `HEV_OFF_MASK_A: begin
        rdata_d = {24'h0, event_mask_a_q};
      end
      `HEV_OFF_MASK_B: begin
        rdata_d = {24'h0, event_mask_b_q};
      end
      `HEV_OFF_CFG: begin
        rdata_d = {28'h0, cfg_q};
      end
      `HEV_OFF_FREQ: begin
        rdata_d = {freq_hi_q, freq_lo_q};
      end
      `HEV_OFF_STATUS: begin
        rdata_d = {29'h0, irq_q, state_q};
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered at the address edge, so it stands through the data phase.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (xfer_req(hsel_i, htrans_i) && !hwrite_i && hready_i) begin
      hrdata_o <= rdata_d;
    end
  end

endmodule : hev_core

/* logic/hev_pkg.sv */
// Types for the haptic event diagnostics block.
// Assumes hev_consts.svh is found on the include path.
`include "hev_consts.svh"
package hev_pkg;
  typedef enum logic [1:0] {
    HEV_IDLE  = 2'b00,
    HEV_DRIVE = 2'b01,
    HEV_HOLD  = 2'b10
  } hev_state_t;
endpackage : hev_pkg
